//--- src/rod_consts.svh
// constants for the op-code decoder: field positions, register numbers, bus offsets
// Overview of operation
// - immediate ops combine the eight-bit op-code constant with accumulator, result to accumulator
// - upper two register address bits come from index register bits 6..5
// - op-code bits 4..0 normally pass straight to address bits 4..0
// - register field 00000 substitutes index bits 4..0, giving indirect access
// - shared general register region forces address bits 6..5 to zero
// - address decode yields data select and write enables for each register
// - implicit ops leave the data source selection unused
// - standard ops except move-accumulator, and bitwise ops, select register data
// - branch and immediate ops select the op-code constant field
// - move-accumulator-to-register selects the accumulator as source
// - a four-bit ALU function code is derived from the op-code
// - instruction register loads only on edges with fetch strobe high
// - fetch strobe in first cycle, or one cycle later for two-cycle ops
// - program counter as destination stretches the op to two cycles
// - after power-down the fetch strobe stays low until master reset
// - master reset clears the instruction register, giving a no-op, and ends the halt state
// - op-code bit 5 picks register or accumulator destination
// - power-down indication holds until the next master reset
`ifndef ROD_CONSTS_SVH
`define ROD_CONSTS_SVH
`define ROD_IR_RESET      12'h0000
`define ROD_OP_POWER_DOWN_OP      12'h0003
`define ROD_DEST_BIT      5
`define ROD_SHARED_HI     2'h1
`define ROD_REG_INDIRECT  5'h00
`define ROD_REG_TIMER     5'h01
`define ROD_REG_PC        5'h02
`define ROD_REG_STATUS    5'h03
`define ROD_REG_POINTER   5'h04
`define ROD_REG_PORT_A    5'h05
`define ROD_REG_PORT_B    5'h06
`define ROD_REG_PORT_C    5'h07
`define ROD_STD_DECSZ     4'hb
`define ROD_STD_INCSZ     4'hf
`define ROD_STD_MOVE_ACCUM_TO_REGISTER      4'h0
`define ROD_APB_STATUS    12'h000
`define ROD_APB_CTRL      12'h004
`define ROD_STAT_PD_BIT   0
`define ROD_STAT_FETCH_BIT 1
`define ROD_STAT_IR_LSB   16
`define ROD_CTRL_MRST_BIT 0
`endif

//--- src/rod_pkg.sv
// types shared by the op-code decoder modules
package rod_pkg;
	typedef enum logic [2:0] {
		ST_FIRST  = 3'b001,
		ST_SECOND = 3'b010,
		ST_HALT   = 3'b100
	} rod_cycle_t;
	typedef enum logic [1:0] {
		SEL_SPECIAL = 2'h0,
		SEL_GENERAL = 2'h1,
		SEL_INSTR   = 2'h2,
		SEL_ACCUM   = 2'h3
	} rod_sel_t;
	typedef enum logic [3:0] {
		ALF_PASN = 4'h0, ALF_CLR  = 4'h1, ALF_SUB  = 4'h2, ALF_DEC  = 4'h3,
		ALF_OR   = 4'h4, ALF_AND  = 4'h5, ALF_XOR  = 4'h6, ALF_ADD  = 4'h7,
		ALF_PASZ = 4'h8, ALF_NOT  = 4'h9, ALF_INC  = 4'ha, ALF_ROR  = 4'hb,
		ALF_ROL  = 4'hc, ALF_SWPN = 4'hd, ALF_BCLR = 4'he, ALF_BSET = 4'hf
	} rod_alf_t;
endpackage

//--- src/rod_addr_router.sv
// register address router: bank bits, indirect substitution, shared region fold
`timescale 1ns/1ps
`include "rod_consts.svh"
module rod_addr_router (
	input  wire logic [4:0] reg_field_in,
	input  wire logic [7:0] pointer_in,
	output logic      [6:0] address_out
);
	logic [4:0] low_bits;
	logic       shared_region;
	assign low_bits = (reg_field_in == `ROD_REG_INDIRECT) ? pointer_in[4:0]
		: reg_field_in;
	assign shared_region = (low_bits[4:3] == `ROD_SHARED_HI);
	assign address_out = {shared_region ? 2'b00 : pointer_in[6:5], low_bits};
endmodule

//--- src/rod_apb_regs.sv
// apb slave: status view of the decoder and a software master reset control
`timescale 1ns/1ps
`include "rod_consts.svh"
module rod_apb_regs (
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	input  wire logic        power_down_in,
	input  wire logic        fetch_in,
	input  wire logic [11:0] instr_in,
	output logic             soft_reset_out
);
	logic        hit_status;
	logic        hit_ctrl;
	logic        access;
	logic [31:0] status_word;
	assign access = psel_in & penable_in;
	assign hit_status = (paddr_in == `ROD_APB_STATUS);
	assign hit_ctrl = (paddr_in == `ROD_APB_CTRL);
	assign pready_out = 1'b1;
	assign pslverr_out = access & ~(hit_status | hit_ctrl);
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[`ROD_STAT_PD_BIT] = power_down_in;
		status_word[`ROD_STAT_FETCH_BIT] = fetch_in;
		status_word[`ROD_STAT_IR_LSB +: 12] = instr_in;
	end
	assign prdata_out = (access & ~pwrite_in & hit_status) ? status_word : 32'h0000_0000;
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			soft_reset_out <= 1'b0;
		end else begin
			soft_reset_out <= access & pwrite_in & hit_ctrl & pwdata_in[`ROD_CTRL_MRST_BIT];
		end
	end
endmodule

//--- src/rod_op_decode_unit.sv
// op-code decoder: instruction register, address routing, write enables, alu code, fetch pacing
`timescale 1ns/1ps
`include "rod_consts.svh"
module rod_op_decode_unit (
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	input  wire logic        master_reset_in,
	input  wire logic [11:0] opcode_bits_in,
	input  wire logic [7:0]  indirect_pointer_value_in,
	input  wire logic        skip_condition_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	output logic      [11:0] instruction_out,
	output logic      [6:0]  register_address_out,
	output logic      [1:0]  data_source_sel_out,
	output logic      [3:0]  alu_function_code_out,
	output logic      [7:0]  immediate_data_out,
	output logic             accumulator_write_enable_out,
	output logic             pointer_write_enable_out,
	output logic             program_counter_load_enable_out,
	output logic             port_a_write_enable_out,
	output logic             port_b_write_enable_out,
	output logic             port_c_write_enable_out,
	output logic             status_write_enable_out,
	output logic             timer_write_enable_out,
	output logic             register_ram_write_enable_out,
	output logic             fetch_next_strobe_out,
	output logic             power_down_op_out
);
	logic [11:0]         instruction_holding_register;
	rod_pkg::rod_cycle_t state;
	rod_pkg::rod_cycle_t next_state;
	logic                soft_reset;
	logic                any_master_reset;
	logic                cls_implicit;
	logic                cls_standard;
	logic                cls_bitwise;
	logic                cls_branch;
	logic                cls_immediate;
	logic                op_move_accum_to_register;
	logic                op_power_down_op;
	logic                op_skip;
	logic                dest_register;
	logic                reg_write;
	logic                pc_dest;
	logic                two_cycle;
	logic                halted;
	logic                active;
	logic [3:0]          std_op;
	logic [4:0]          low_adr;
	rod_pkg::rod_alf_t   std_alf;
	rod_pkg::rod_alf_t   alu_function_code;
	rod_pkg::rod_sel_t   sel;

	rod_addr_router u_router (
		.reg_field_in (instruction_holding_register[4:0]),
		.pointer_in   (indirect_pointer_value_in),
		.address_out  (register_address_out)
	);

	rod_apb_regs u_regs (
		.clk_in         (clk_in),
		.reset_in       (reset_in),
		.psel_in        (psel_in),
		.penable_in     (penable_in),
		.pwrite_in      (pwrite_in),
		.paddr_in       (paddr_in),
		.pwdata_in      (pwdata_in),
		.prdata_out     (prdata_out),
		.pready_out     (pready_out),
		.pslverr_out    (pslverr_out),
		.power_down_in  (power_down_op_out),
		.fetch_in       (fetch_next_strobe_out),
		.instr_in       (instruction_holding_register),
		.soft_reset_out (soft_reset)
	);

	assign any_master_reset = master_reset_in | soft_reset;

	// instruction class decode, all from the held op-code
	assign cls_implicit = (instruction_holding_register[11:5] == 7'h00);
	assign cls_standard = (instruction_holding_register[11:10] == 2'h0) & ~cls_implicit;
	assign cls_bitwise = (instruction_holding_register[11:10] == 2'h1);
	assign cls_branch = (instruction_holding_register[11:10] == 2'h2);
	assign cls_immediate = (instruction_holding_register[11:10] == 2'h3);
	assign std_op = instruction_holding_register[9:6];
	assign op_move_accum_to_register = cls_standard & (std_op == `ROD_STD_MOVE_ACCUM_TO_REGISTER);
	assign op_power_down_op = (instruction_holding_register == `ROD_OP_POWER_DOWN_OP);
	assign op_skip = (cls_standard & ((std_op == `ROD_STD_DECSZ) | (std_op == `ROD_STD_INCSZ)))
		| (cls_bitwise & instruction_holding_register[9]);
	assign dest_register = instruction_holding_register[`ROD_DEST_BIT];
	assign reg_write = (cls_standard & dest_register)
		| (cls_bitwise & ~instruction_holding_register[9]);
	assign low_adr = register_address_out[4:0];
	assign pc_dest = reg_write & (low_adr == `ROD_REG_PC);
	assign two_cycle = cls_branch | pc_dest | (op_skip & skip_condition_in);
	assign halted = (state == rod_pkg::ST_HALT);
	assign active = ~halted;

	// write enables from the routed address, the accumulator enable from the op class
	assign accumulator_write_enable_out = active
		& ((cls_standard & ~dest_register) | cls_immediate);
	assign timer_write_enable_out = active & reg_write & (low_adr == `ROD_REG_TIMER);
	assign program_counter_load_enable_out = active & pc_dest;
	assign status_write_enable_out = active & reg_write & (low_adr == `ROD_REG_STATUS);
	assign pointer_write_enable_out = active & reg_write & (low_adr == `ROD_REG_POINTER);
	assign port_a_write_enable_out = active & reg_write & (low_adr == `ROD_REG_PORT_A);
	assign port_b_write_enable_out = active & reg_write & (low_adr == `ROD_REG_PORT_B);
	assign port_c_write_enable_out = active & reg_write & (low_adr == `ROD_REG_PORT_C);
	assign register_ram_write_enable_out = active & reg_write & low_adr[4] | active & reg_write
		& (low_adr[4:3] == 2'h1);

	// data source select
	always_comb begin
		if (cls_branch | cls_immediate) begin
			sel = rod_pkg::SEL_INSTR;
		end else if (op_move_accum_to_register) begin
			sel = rod_pkg::SEL_ACCUM;
		end else if (cls_standard | cls_bitwise) begin
			sel = (low_adr[4:3] == 2'h0) ? rod_pkg::SEL_SPECIAL
				: rod_pkg::SEL_GENERAL;
		end else begin
			sel = rod_pkg::SEL_SPECIAL;
		end
	end
	assign data_source_sel_out = sel;
	assign immediate_data_out = instruction_holding_register[7:0];

	// alu function code
	always_comb begin
		unique case (std_op)
			4'h0: std_alf = rod_pkg::ALF_PASN;
			4'h1: std_alf = rod_pkg::ALF_CLR;
			4'h2: std_alf = rod_pkg::ALF_SUB;
			4'h3: std_alf = rod_pkg::ALF_DEC;
			4'h4: std_alf = rod_pkg::ALF_OR;
			4'h5: std_alf = rod_pkg::ALF_AND;
			4'h6: std_alf = rod_pkg::ALF_XOR;
			4'h7: std_alf = rod_pkg::ALF_ADD;
			4'h8: std_alf = rod_pkg::ALF_PASZ;
			4'h9: std_alf = rod_pkg::ALF_NOT;
			4'ha: std_alf = rod_pkg::ALF_INC;
			4'hb: std_alf = rod_pkg::ALF_DEC;
			4'hc: std_alf = rod_pkg::ALF_ROR;
			4'hd: std_alf = rod_pkg::ALF_ROL;
			4'he: std_alf = rod_pkg::ALF_SWPN;
			4'hf: std_alf = rod_pkg::ALF_INC;
		endcase
	end
	always_comb begin
		alu_function_code = rod_pkg::ALF_PASN;
		if (cls_standard) begin
			alu_function_code = std_alf;
		end else if (cls_bitwise) begin
			unique case (instruction_holding_register[9:8])
				2'h0: alu_function_code = rod_pkg::ALF_BCLR;
				2'h1: alu_function_code = rod_pkg::ALF_BSET;
				2'h2, 2'h3: alu_function_code = rod_pkg::ALF_PASN;
			endcase
		end else if (cls_immediate) begin
			unique case (instruction_holding_register[9:8])
				2'h0: alu_function_code = rod_pkg::ALF_PASN;
				2'h1: alu_function_code = rod_pkg::ALF_OR;
				2'h2: alu_function_code = rod_pkg::ALF_AND;
				2'h3: alu_function_code = rod_pkg::ALF_XOR;
			endcase
		end
	end
	assign alu_function_code_out = alu_function_code;

	// cycle sequencing and fetch pacing
	always_comb begin
		next_state = state;
		unique case (state)
			rod_pkg::ST_FIRST: begin
				if (op_power_down_op) begin
					next_state = rod_pkg::ST_HALT;
				end else if (two_cycle) begin
					next_state = rod_pkg::ST_SECOND;
				end
			end
			rod_pkg::ST_SECOND: begin
				next_state = rod_pkg::ST_FIRST;
			end
			rod_pkg::ST_HALT: begin
				if (any_master_reset) begin
					next_state = rod_pkg::ST_FIRST;
				end
			end
			default: begin
				next_state = rod_pkg::ST_FIRST;
			end
		endcase
	end
	assign fetch_next_strobe_out = ((state == rod_pkg::ST_FIRST) & ~two_cycle & ~op_power_down_op)
		| (state == rod_pkg::ST_SECOND);
	assign power_down_op_out = halted | op_power_down_op;
	assign instruction_out = instruction_holding_register;

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			state <= rod_pkg::ST_FIRST;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in | any_master_reset) begin
			instruction_holding_register <= `ROD_IR_RESET;
		end else if (fetch_next_strobe_out) begin
			instruction_holding_register <= opcode_bits_in;
		end
	end

	property p_imm_acc;
		@(posedge clk_in) disable iff (reset_in)
		cls_immediate |-> accumulator_write_enable_out && data_source_sel_out == 2'h2;
	endproperty
	a_imm_acc: assert property (p_imm_acc) else $error("immediate op misrouted");
	property p_bank;
		@(posedge clk_in) disable iff (reset_in)
		register_address_out[4:3] != 2'h1 |->
			register_address_out[6:5] == indirect_pointer_value_in[6:5];
	endproperty
	a_bank: assert property (p_bank) else $error("bank bits wrong");
	property p_shared;
		@(posedge clk_in) disable iff (reset_in)
		register_address_out[4:3] == 2'h1 |-> register_address_out[6:5] == 2'h0;
	endproperty
	a_shared: assert property (p_shared) else $error("shared region not folded");
	property p_indirect;
		@(posedge clk_in) disable iff (reset_in)
		instruction_holding_register[4:0] == 5'h00 |->
			register_address_out[4:0] == indirect_pointer_value_in[4:0];
	endproperty
	a_indirect: assert property (p_indirect) else $error("indirect address wrong");
	property p_move_accum_to_register;
		@(posedge clk_in) disable iff (reset_in)
		op_move_accum_to_register |-> data_source_sel_out == 2'h3;
	endproperty
	a_move_accum_to_register: assert property (p_move_accum_to_register) else $error("move accumulator source wrong");
	property p_hold_ir;
		@(posedge clk_in) disable iff (reset_in)
		!fetch_next_strobe_out && !any_master_reset |=> $stable(instruction_holding_register);
	endproperty
	a_hold_ir: assert property (p_hold_ir) else $error("op-code loaded without fetch");
	property p_branch;
		@(posedge clk_in) disable iff (reset_in)
		cls_branch && state == rod_pkg::ST_FIRST && !any_master_reset
			|-> !fetch_next_strobe_out ##1 fetch_next_strobe_out;
	endproperty
	a_branch: assert property (p_branch) else $error("branch not two cycles");
	property p_pcdest;
		@(posedge clk_in) disable iff (reset_in)
		program_counter_load_enable_out && state == rod_pkg::ST_FIRST |-> !fetch_next_strobe_out;
	endproperty
	a_pcdest: assert property (p_pcdest) else $error("pc destination not stretched");
	property p_halt;
		@(posedge clk_in) disable iff (reset_in)
		power_down_op_out && !any_master_reset |=> power_down_op_out && !fetch_next_strobe_out;
	endproperty
	a_halt: assert property (p_halt) else $error("power-down released early");
	property p_master_reset;
		@(posedge clk_in) disable iff (reset_in)
		master_reset_in |=> instruction_holding_register == 12'h000;
	endproperty
	a_master_reset: assert property (p_master_reset) else $error("master reset left op-code");
	property p_soft;
		@(posedge clk_in) disable iff (reset_in)
		soft_reset |=> instruction_holding_register == `ROD_IR_RESET;
	endproperty
	a_soft: assert property (p_soft) else $error("soft reset left op-code");
	property p_direct;
		@(posedge clk_in) disable iff (reset_in)
		instruction_holding_register[4:0] != `ROD_REG_INDIRECT |->
			register_address_out[4:0] == instruction_holding_register[4:0];
	endproperty
	a_direct: assert property (p_direct) else $error("direct address wrong");
	property p_implicit_sel;
		@(posedge clk_in) disable iff (reset_in)
		cls_implicit |-> data_source_sel_out == 2'h0 && !accumulator_write_enable_out;
	endproperty
	a_implicit_sel: assert property (p_implicit_sel) else $error("implicit op routed");
	property p_acc_dest;
		@(posedge clk_in) disable iff (reset_in)
		cls_standard && !instruction_holding_register[`ROD_DEST_BIT]
			|-> accumulator_write_enable_out;
	endproperty
	a_acc_dest: assert property (p_acc_dest) else $error("accumulator not written");
	property p_timer_we;
		@(posedge clk_in) disable iff (reset_in)
		timer_write_enable_out |-> register_address_out[4:0] == `ROD_REG_TIMER
			&& !accumulator_write_enable_out;
	endproperty
	a_timer_we: assert property (p_timer_we) else $error("timer enable misdecoded");
	property p_single;
		@(posedge clk_in) disable iff (reset_in)
		cls_immediate && state == rod_pkg::ST_FIRST |-> fetch_next_strobe_out;
	endproperty
	a_single: assert property (p_single) else $error("immediate op stretched");
endmodule

//--- tb/rod_far_model.sv
// far-side model: index register and skip result as the alu and register file present them
`timescale 1ns/1ps
module rod_far_model (
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	input  wire logic        fetch_in,
	input  wire logic [11:0] instr_in,
	input  wire logic [7:0]  pointer_plan_in,
	input  wire logic        skip_plan_in,
	output logic      [7:0]  pointer_value_out,
	output logic             skip_condition_out
);
	logic skip_armed;
	logic is_skip_op;
	// only the conditional skip ops can ever report a taken skip
	assign is_skip_op = (instr_in[11:6] == 6'h0b) || (instr_in[11:6] == 6'h0f)
		|| (instr_in[11:9] == 3'b011);
	assign skip_condition_out = skip_armed & is_skip_op;
	// index value and skip plan change only when a new op-code is taken
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			pointer_value_out <= 8'h00;
			skip_armed        <= 1'b0;
		end else if (fetch_in) begin
			pointer_value_out <= pointer_plan_in;
			skip_armed        <= skip_plan_in;
		end
	end
endmodule

//--- tb/risc_op_decode_routing_test.sv
// testbench for the op-code decoder: random and directed decode, halt, resets, apb status
`timescale 1ns/1ps
`include "rod_consts.svh"
module risc_op_decode_routing_test;
	typedef struct {
		logic [11:0] op;
		logic        full;
		logic [6:0]  addr;
		logic [1:0]  sel;
		logic [3:0]  code;
		logic [8:0]  we;
		int          cyc;
	} rod_note_t;
	logic        clk_in = 0, reset_in = 1, mrst = 0, skip_plan = 0, psel = 0, penable = 0;
	logic        pwrite = 0, pready, pslverr, skip_cond, strobe, pdown, active = 0;
	logic [11:0] opcode = 12'h000, paddr = 12'h000, instr;
	logic [7:0]  ptr_plan = 8'h01, ptr_val, imm;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic [6:0]  addr;
	logic [1:0]  sel;
	logic [3:0]  code;
	logic [8:0]  we;
	logic [32:0] apb_e;
	rod_note_t   cur;
	rod_note_t   dec_q[$];
	logic [32:0] apb_q[$];
	int          errors = 0, n_tests = 0, cnt = 0;

	rod_op_decode_unit rod_op_decode_unit_i (.clk_in(clk_in), .reset_in(reset_in),
		.master_reset_in(mrst), .opcode_bits_in(opcode), .indirect_pointer_value_in(ptr_val),
		.skip_condition_in(skip_cond), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .instruction_out(instr),
		.register_address_out(addr), .data_source_sel_out(sel), .alu_function_code_out(code),
		.immediate_data_out(imm), .accumulator_write_enable_out(we[8]),
		.pointer_write_enable_out(we[7]), .program_counter_load_enable_out(we[6]),
		.port_a_write_enable_out(we[5]), .port_b_write_enable_out(we[4]),
		.port_c_write_enable_out(we[3]), .status_write_enable_out(we[2]),
		.timer_write_enable_out(we[1]), .register_ram_write_enable_out(we[0]),
		.fetch_next_strobe_out(strobe), .power_down_op_out(pdown));
	rod_far_model rod_far_model_i (.clk_in(clk_in), .reset_in(reset_in), .fetch_in(strobe),
		.instr_in(instr), .pointer_plan_in(ptr_plan), .skip_plan_in(skip_plan),
		.pointer_value_out(ptr_val), .skip_condition_out(skip_cond));

	initial begin
		forever #2 clk_in = ~clk_in;
	end

	task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic complete_run;
		$display("compares %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	function automatic rod_note_t expect_op(input logic [11:0] op, input logic [7:0] p,
			input logic s);
		rod_note_t  n;
		logic [4:0] lo;
		logic [8:0] rw;
		logic [1:0] rsel;
		logic [3:0] std_code [16];
		logic [3:0] imm_code [4];
		std_code = '{rod_pkg::ALF_PASN, rod_pkg::ALF_CLR, rod_pkg::ALF_SUB, rod_pkg::ALF_DEC,
			rod_pkg::ALF_OR, rod_pkg::ALF_AND, rod_pkg::ALF_XOR, rod_pkg::ALF_ADD,
			rod_pkg::ALF_PASZ, rod_pkg::ALF_NOT, rod_pkg::ALF_INC, rod_pkg::ALF_DEC,
			rod_pkg::ALF_ROR, rod_pkg::ALF_ROL, rod_pkg::ALF_SWPN, rod_pkg::ALF_INC};
		imm_code = '{rod_pkg::ALF_PASN, rod_pkg::ALF_OR, rod_pkg::ALF_AND, rod_pkg::ALF_XOR};
		lo = (op[4:0] == `ROD_REG_INDIRECT) ? p[4:0] : op[4:0];
		rw = {1'b0, lo == `ROD_REG_POINTER, lo == `ROD_REG_PC, lo == `ROD_REG_PORT_A,
			lo == `ROD_REG_PORT_B, lo == `ROD_REG_PORT_C, lo == `ROD_REG_STATUS,
			lo == `ROD_REG_TIMER, lo >= 5'h08};
		rsel = (lo >= 5'h08) ? rod_pkg::SEL_GENERAL : rod_pkg::SEL_SPECIAL;
		n = '{op, 1'b1, {(lo[4:3] == `ROD_SHARED_HI) ? 2'b00 : p[6:5], lo},
			rod_pkg::SEL_INSTR, rod_pkg::ALF_PASN, 9'h000, 1};
		case (op[11:10])
			2'b00: begin
				n.sel = rod_pkg::SEL_SPECIAL;
				if (op[11:5] != 7'h00) begin
					n.code = std_code[op[9:6]];
					n.sel = (op[9:6] == `ROD_STD_MOVE_ACCUM_TO_REGISTER) ? rod_pkg::SEL_ACCUM : rsel;
					n.we = op[`ROD_DEST_BIT] ? rw : 9'h100;
					n.cyc = (((op[9:6] == `ROD_STD_DECSZ) || (op[9:6] == `ROD_STD_INCSZ)) && s)
						|| (op[5] && rw[6]) ? 2 : 1;
				end
			end
			2'b01: begin
				n.code = op[9] ? rod_pkg::ALF_PASN : (op[8] ? rod_pkg::ALF_BSET : rod_pkg::ALF_BCLR);
				n.sel = rsel;
				n.we = op[9] ? 9'h000 : rw;
				n.cyc = (op[9] && s) || (!op[9] && rw[6]) ? 2 : 1;
			end
			2'b10: begin
				n.full = 1'b0;
				n.cyc = 2;
			end
			default: begin
				n.code = imm_code[op[9:8]];
				n.we = 9'h100;
			end
		endcase
		return n;
	endfunction

	task automatic present(input logic [11:0] op, input logic [7:0] p, input logic s);
		int n;
		n = 0;
		opcode <= op;
		ptr_plan <= p;
		skip_plan <= s;
		do begin
			@(posedge clk_in);
			n++;
		end while (strobe !== 1'b1 && n < 20);
		if (n >= 20) begin
			errors++;
			complete_run();
		end
	endtask

	task automatic issue(input logic [11:0] op, input logic [7:0] p, input logic s);
		dec_q.push_back(expect_op(op, p, s));
		present(op, p, s);
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
			input logic [32:0] exp);
		@(posedge clk_in);
		apb_q.push_back(exp);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_in);
		penable <= 1'b1;
		do begin
			@(posedge clk_in);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// apb results taken at the edge that completes the access
	always @(posedge clk_in) begin
		if (psel && penable && pready === 1'b1 && apb_q.size() > 0) begin
			apb_e = apb_q.pop_front();
			cmp("pslverr", apb_e[32], pslverr);
			cmp("prdata", apb_e[31:0], prdata);
		end
	end

	// decode results checked mid-cycle, then the cycle count up to the next fetch
	always @(negedge clk_in) begin
		if (reset_in || mrst)
			active = 1'b0;
		else begin
			if (!active && dec_q.size() > 0 && instr === dec_q[0].op) begin
				cur = dec_q.pop_front();
				active = 1'b1;
				cnt = 0;
				cmp("alu code", cur.code, code);
				cmp("data select", cur.sel, sel);
				cmp("immediate", cur.op[7:0], imm);
				if (cur.full) begin
					cmp("address", cur.addr, addr);
					cmp("enables", cur.we, we);
				end
			end
			if (active) begin
				cnt++;
				if (strobe === 1'b1) begin
					cmp("cycles", cur.cyc, cnt);
					active = 1'b0;
				end
			end
		end
	end

	initial begin
		#20000;
		errors++;
		complete_run();
	end

	initial begin
		logic [11:0] op;
		logic [7:0]  p;
		void'($urandom(32'hc07f));
		repeat (12) @(posedge clk_in);
		reset_in <= 1'b0;
		@(posedge clk_in);
		issue(12'h1e2, 8'h62, 1'b0);
		issue(12'h2e0, 8'h4c, 1'b1);
		issue(12'h029, 8'h40, 1'b0);
		issue(12'hd5a, 8'h21, 1'b0);
		issue(12'h004, 8'h21, 1'b0);
		issue(12'h9ab, 8'h21, 1'b0);
		issue(12'h731, 8'h70, 1'b1);
		for (int i = 0; i < 300; i++) begin
			op = 12'($urandom);
			p = 8'($urandom);
			if (op[11:5] == 7'h00)
				op[5] = 1'b1;
			if (op[11:9] == 3'b101)
				op = 12'ha00;
			if (p[4:0] == 5'h00)
				p[0] = 1'b1;
			issue(op, p, 1'($urandom));
		end
		present(`ROD_OP_POWER_DOWN_OP, 8'h01, 1'b0);
		opcode <= 12'h000;
		repeat (6) begin
			@(negedge clk_in);
			cmp("power down", 1'b1, pdown);
			cmp("fetch strobe", 1'b0, strobe);
		end
		apb(1'b0, `ROD_APB_STATUS, 32'h0, {1'b0, 32'h0003_0001});
		apb(1'b1, `ROD_APB_CTRL, 32'h0000_0001, 33'h0_0000_0000);
		repeat (3) @(posedge clk_in);
		apb(1'b0, `ROD_APB_STATUS, 32'h0, {1'b0, 32'h0000_0002});
		apb(1'b0, 12'h008, 32'h0, {1'b1, 32'h0000_0000});
		@(posedge clk_in);
		present(`ROD_OP_POWER_DOWN_OP, 8'h01, 1'b0);
		opcode <= 12'h000;
		repeat (3) @(posedge clk_in);
		mrst <= 1'b1;
		repeat (2) @(posedge clk_in);
		mrst <= 1'b0;
		repeat (3) @(posedge clk_in);
		apb(1'b0, `ROD_APB_STATUS, 32'h0, {1'b0, 32'h0000_0002});
		@(posedge clk_in);
		issue(12'hf3c, 8'h21, 1'b0);
		repeat (4) @(posedge clk_in);
		complete_run();
	end
endmodule
